// ===== shared/psc_pkg.sv
package psc_pkg;
   // Reset pulse the reset pin must hold, and the clock it is measured on
   localparam int unsigned RST_MIN_NS = 300_000;
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned RST_MIN_CYC = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RST_CNT_W = 17;
   // Capture cycles after reset: three sync stages, the agreement register and the strap register
   localparam logic [2:0] STRAP_SETTLE_CYC = 3'h5;
   localparam int unsigned NUM_PORTS = 4;
   // Fixed upper part of the serial slave address
   localparam logic [2:0] ADDR_UPPER = 3'h2;
   localparam int unsigned ADDR_UPPER_POS = 4;
   // Values after reset
   localparam logic [3:0] STRAP_ADDR_RST = 4'hf;
   localparam logic STRAP_AUTO_RST = 1'b0;
   localparam logic STRAP_MID_RST = 1'b0;
   localparam logic [1:0] MODE_RST = 2'h0;

   // Per-port operating mode
   typedef enum logic [1:0]
   {
      PSC_SHUTDOWN = 2'b00,
      PSC_MANUAL = 2'b01,
      PSC_SEMI = 2'b10,
      PSC_AUTO = 2'b11
   } psc_mode_t;

   // Straps as captured
   typedef struct packed
   {
      logic [3:0] addr;
      logic auto_on;
      logic midspan;
   } psc_straps_t;

   // Software mode command
   typedef struct packed
   {
      logic valid;
      logic [3:0] port_sel;
      psc_mode_t mode;
   } psc_mode_cmd_t;
endpackage

// ===== verilog/psc_sync3.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change is taken once stages two and three agree
module psc_sync3 #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
   logic [WIDTH-1:0] out_d;

   // Stage one feeds only stage two
   always_comb
   begin
      out_d = out_q;
      for (int i = 0; i < WIDTH; i++)
      begin
         if (s2_q[i] == s3_q[i])
         begin
            out_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         out_q <= RST_VAL;
      end
      else if (ce)
      begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end

   assign sync_out = out_q;
endmodule

// ===== verilog/psc_pin_ctrl.sv
`timescale 1ns/1ps
// How it works
// [R01] Reset pin low 300us restores all defaults
// [R02] Straps captured on reset pin rising edge
// [R03] Midspan strap also sampled after power-up
// [R04] Midspan low means endpoint, high midspan
// [R05] Interrupt low while faults stand uncleared
// [R06] Slave address is 010 plus strap bits
// [R07] Integrator ties serial data lines together
// [R08] Each port shutdown pin turns port off
// [R09] Auto strap picks auto or shutdown start
// [R10] Software selects modes from shutdown mode
// [R11] Software may leave auto despite strap high
// [R12] Probe sine loss kills AC-disconnect ports
// [R13] No address acknowledge while reset persists
// [R14] Strap changes ignored until next reset
// [R15] Asynchronous pins synchronised before use
module psc_pin_ctrl
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   input wire logic reset_pin_n,
   input wire logic uvlo,
   input wire logic over_temp,
   input wire logic soft_reset,
   input wire logic [3:0] slave_addr_straps,
   input wire logic auto_strap,
   input wire logic midspan_strap,
   input wire logic [3:0] port_off_n,
   input wire logic probe_sine_lost,
   input wire logic [3:0] ac_disc_en,
   input wire logic [3:0] fault_set,
   input wire logic [3:0] fault_clr,
   input wire psc_pkg::psc_mode_cmd_t mode_cmd,
   input wire logic [6:0] serial_addr_rx,
   input wire logic serial_addr_valid,
   input wire logic serial_data_in_line,
   output logic serial_data_out_line_oe_n,
   output logic int_oe_n,
   output logic [6:0] slave_addr,
   output logic midspan_mode,
   output logic [7:0] port_modes,
   output logic [3:0] switch_en,
   output logic [3:0] power_block,
   output logic regs_reset
);
   // Synchronised pins
   logic rpin_s;
   logic [3:0] addr_s;
   logic auto_s, mid_s, osc_lost_s;
   logic [3:0] off_n_s;

   // Reset values are the idle pin levels, so no false reset-pin edge follows rst
   psc_sync3 #(.WIDTH(11), .RST_VAL(11'h7cf)) u_sync  // [R15]
   (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .async_in({reset_pin_n, slave_addr_straps, auto_strap, midspan_strap,
                 port_off_n}),
      .sync_out({rpin_s, addr_s, auto_s, mid_s, off_n_s})
   );
   psc_sync3 #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_osc
   (
      .clock(clock),
      .rst(rst),
      .ce(ce),
      .async_in(probe_sine_lost),
      .sync_out(osc_lost_s)
   );

   // Reset-pin low-time counter; short glitches do not reset the device
   logic [psc_pkg::RST_CNT_W-1:0] lowcnt_q, lowcnt_d;
   logic pin_rst_q, pin_rst_d;
   logic in_reset;
   logic [psc_pkg::RST_CNT_W-1:0] rst_min;
   assign rst_min = psc_pkg::RST_CNT_W'(psc_pkg::RST_MIN_CYC);

   always_comb
   begin
      lowcnt_d = lowcnt_q;
      pin_rst_d = pin_rst_q;
      if (rpin_s)
      begin
         lowcnt_d = '0;
         pin_rst_d = 1'b0;  // [R02]
      end
      else if (lowcnt_q < rst_min - 1'b1)
      begin
         lowcnt_d = lowcnt_q + 1'b1;
      end
      else
      begin
         pin_rst_d = 1'b1;  // [R01]
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         lowcnt_q <= '0;
         pin_rst_q <= 1'b0;
      end
      else if (ce)
      begin
         lowcnt_q <= lowcnt_d;
         pin_rst_q <= pin_rst_d;
      end
   end

   // Any persisting reset cause holds the register map in defaults
   assign in_reset = pin_rst_q | uvlo | over_temp | soft_reset;

   // Strap capture: live while in reset or at power-up, frozen afterwards
   psc_pkg::psc_straps_t straps_q, straps_d;
   // Capture runs on after the causes clear until the synchronisers hold the pins
   logic [2:0] capture_q, capture_d;
   logic busy, hold_d;
   logic [3:0] fault_q, fault_d;
   logic [7:0] modes_q, modes_d;
   logic int_q, int_d;
   logic ack_en_q, ack_en_d;

   // Straps still settling or a reset cause present
   assign busy = in_reset | (capture_q != 3'h0);

   always_comb
   begin
      straps_d = straps_q;
      capture_d = 3'h0;
      if (in_reset)
      begin
         capture_d = psc_pkg::STRAP_SETTLE_CYC;
      end
      else if (capture_q != 3'h0)
      begin
         capture_d = capture_q - 3'h1;
      end
      modes_d = modes_q;
      fault_d = fault_q;
      if (busy)
      begin
         // Capture continues until the synchronised pins have settled  [R02]
         straps_d.addr = addr_s;  // [R06]
         straps_d.auto_on = auto_s;  // [R09]
         straps_d.midspan = mid_s;  // [R03]
         for (int p = 0; p < 4; p++)
         begin
            modes_d[2*p +: 2] = auto_s ? 2'(psc_pkg::PSC_AUTO) : 2'(psc_pkg::PSC_SHUTDOWN);  // [R09]
         end
         fault_d = '0;  // [R05]
      end
      else
      begin
         // Strap pins are not looked at here  [R14]
         for (int p = 0; p < 4; p++)
         begin
            if (mode_cmd.valid && mode_cmd.port_sel[p])
            begin
               modes_d[2*p +: 2] = mode_cmd.mode;  // [R10] [R11]
            end
            // Set wins over clear
            if (fault_clr[p])
            begin
               fault_d[p] = 1'b0;
            end
            if (fault_set[p])
            begin
               fault_d[p] = 1'b1;  // [R05]
            end
         end
      end
      int_d = ~(|fault_d);  // [R05]
      hold_d = in_reset | (capture_d != 3'h0);
      ack_en_d = ~hold_d;  // [R13]
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         straps_q <= {psc_pkg::STRAP_ADDR_RST, psc_pkg::STRAP_AUTO_RST,
                      psc_pkg::STRAP_MID_RST};
         capture_q <= psc_pkg::STRAP_SETTLE_CYC;  // Power-up sample  [R03]
         modes_q <= {4{psc_pkg::MODE_RST}};
         fault_q <= '0;
         int_q <= 1'b1;
         ack_en_q <= 1'b0;
      end
      else if (ce)
      begin
         straps_q <= straps_d;
         capture_q <= capture_d;
         modes_q <= modes_d;
         fault_q <= fault_d;
         int_q <= int_d;
         ack_en_q <= ack_en_d;
      end
   end

   // Port switch control: shutdown pin and probe-loss gate power per port
   logic [3:0] sw_q, sw_d, blk_q, blk_d;
   logic sda_oe_n_q, sda_oe_n_d;
   logic [6:0] addr_q, addr_d;
   logic mid_q, mid_d;
   logic regs_rst_q;

   always_comb
   begin
      for (int p = 0; p < 4; p++)
      begin
         blk_d[p] = osc_lost_s & ac_disc_en[p];  // [R12]
         sw_d[p] = off_n_s[p] & ~blk_d[p] & ~busy
                   & (modes_q[2*p +: 2] != 2'(psc_pkg::PSC_SHUTDOWN));  // [R08]
      end
      addr_d = {psc_pkg::ADDR_UPPER, straps_q.addr};  // [R06]
      mid_d = straps_q.midspan;  // [R04]
      // Acknowledge only our own address, and never during reset
      // A fresh reset cause blocks the acknowledge in the very cycle it appears
      sda_oe_n_d = ~(ack_en_q & ~in_reset & serial_addr_valid
                     & (serial_addr_rx == addr_q));  // [R13]
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         sw_q <= '0;
         blk_q <= '0;
         addr_q <= {psc_pkg::ADDR_UPPER, psc_pkg::STRAP_ADDR_RST};
         mid_q <= psc_pkg::STRAP_MID_RST;
         sda_oe_n_q <= 1'b1;
         regs_rst_q <= 1'b1;
      end
      else if (ce)
      begin
         sw_q <= sw_d;
         blk_q <= blk_d;
         addr_q <= addr_d;
         mid_q <= mid_d;
         sda_oe_n_q <= sda_oe_n_d;
         regs_rst_q <= hold_d;  // [R01]
      end
   end

   // Open-drain pins: enable low while pulling the line low
   assign int_oe_n = int_q;
   assign serial_data_out_line_oe_n = sda_oe_n_q;
   assign slave_addr = addr_q;
   assign midspan_mode = mid_q;
   assign port_modes = modes_q;
   assign switch_en = sw_q;
   assign power_block = blk_q;
   assign regs_reset = regs_rst_q;
endmodule

// ===== sim/psc_pin_ctrl_checker.sv
`timescale 1ns/1ps
module psc_pin_ctrl_checker
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [3:0] port_off_n,
   input wire logic probe_sine_lost,
   input wire logic [3:0] ac_disc_en,
   input wire logic [3:0] fault_set,
   input wire logic [3:0] fault_clr,
   input wire logic serial_data_out_line_oe_n,
   input wire logic int_oe_n,
   input wire logic [6:0] slave_addr,
   input wire logic [3:0] switch_en,
   input wire logic [3:0] power_block,
   input wire logic regs_reset
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // Async pins pass a synchroniser and an output register, so allow six cycles
   sequence s_all_off;
      (port_off_n == 4'h0) [*6];
   endsequence
   sequence s_sine_gone;
      (probe_sine_lost && $stable(ac_disc_en)) [*6];
   endsequence
   // Strap capture may still land a few cycles after the reset causes clear
   sequence s_running;
      !regs_reset [*8];
   endsequence
   a_addr_top: assert property (slave_addr[6:4] == 3'h2)
      else $error("address top bits");
   a_off_switch: assert property (s_all_off |-> switch_en == 4'h0)
      else $error("switch on while off");
   a_sine_block: assert property (s_sine_gone |->
      power_block == ac_disc_en && (switch_en & ac_disc_en) == 4'h0)
      else $error("probe loss not blocking");
   // A reset cause raised in the set cycle shows on regs_reset one cycle later
   a_fault_int: assert property (fault_set != 4'h0 && !regs_reset ##1 !regs_reset |-> !int_oe_n)
      else $error("interrupt late");
   a_int_release: assert property ($rose(int_oe_n) |->
      $past(fault_clr) != 4'h0 || regs_reset || $past(regs_reset))
      else $error("interrupt freed early");
   a_ack_reset: assert property (regs_reset |-> serial_data_out_line_oe_n)
      else $error("ack during reset");
   a_straps_held: assert property (s_running |-> $stable(slave_addr))
      else $error("straps moved");
   a_reset_int: assert property (regs_reset [*2] |-> int_oe_n && switch_en == 4'h0)
      else $error("reset values");
endmodule

// ===== sim/psc_host_model.sv
`timescale 1ns/1ps
module psc_host_model
(
   input wire logic clock,
   input wire logic sda_oe_n,
   output logic sda_line,
   output logic [6:0] addr_rx,
   output logic addr_valid
);
   // Both data lines tied into one pulled-up wire
   assign sda_line = sda_oe_n;
   initial
   begin
      addr_rx = 7'h00;
      addr_valid = 1'b0;
   end
   // Released address shows the inverse so a stale match cannot pass
   task automatic send_addr(input logic [6:0] a);
      @(negedge clock);
      addr_rx = a;
      addr_valid = 1'b1;
      @(negedge clock);
      addr_valid = 1'b0;
      addr_rx = ~a;
   endtask
endmodule

// ===== sim/psc_pin_ctrl_bench.sv
`timescale 1ns/1ps
module psc_pin_ctrl_bench;
   logic clock = 1'b0, rst = 1'b1, reset_pin_n = 1'b1, uvlo = 1'b0, probe_sine_lost = 1'b0;
   logic auto_strap = 1'b1, midspan_strap = 1'b1, serial_data_in_line, serial_addr_valid;
   logic [3:0] slave_addr_straps = 4'h0, port_off_n = 4'hf, ac_disc_en = 4'h0;
   logic [3:0] fault_set = 4'h0, fault_clr = 4'h0, switch_en, power_block;
   logic serial_data_out_line_oe_n, int_oe_n, midspan_mode, regs_reset;
   logic [6:0] slave_addr, serial_addr_rx;
   logic [7:0] port_modes;
   logic [11:0] pick;
   logic [11:0] notes [$];
   psc_pkg::psc_mode_cmd_t mode_cmd = '0;
   int seed, r, miscompares = 0, tests_run = 0;
   always #2 clock = ~clock;
   psc_pin_ctrl i_psc_pin_ctrl (.clock, .rst, .ce(1'b1), .reset_pin_n, .uvlo,
      .over_temp(1'b0), .soft_reset(1'b0), .slave_addr_straps, .auto_strap, .midspan_strap,
      .port_off_n, .probe_sine_lost, .ac_disc_en, .fault_set, .fault_clr, .mode_cmd,
      .serial_addr_rx, .serial_addr_valid, .serial_data_in_line, .serial_data_out_line_oe_n,
      .int_oe_n, .slave_addr, .midspan_mode, .port_modes, .switch_en, .power_block,
      .regs_reset);
   psc_host_model i_psc_host_model (.clock, .sda_oe_n(serial_data_out_line_oe_n),
      .sda_line(serial_data_in_line), .addr_rx(serial_addr_rx), .addr_valid(serial_addr_valid));
   task automatic conclude;
      if (miscompares == 0 && tests_run > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic idle(input int c);
      repeat (c) @(negedge clock);
   endtask
   task automatic note(input logic [3:0] k, input logic [7:0] e);
      notes.push_back({k, e});
      @(negedge clock);
   endtask
   // Shared scoring; four-state compare so an unknown output fails
   task automatic tally(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic compare_addr(input logic [7:0] e);
      tally("slave_addr", e, {1'b0, slave_addr});
   endtask
   task automatic compare_modes(input logic [7:0] e);
      tally("port_modes", e, port_modes);
   endtask
   task automatic compare_switch(input logic [7:0] e);
      tally("switch_en", e, {4'h0, switch_en});
   endtask
   task automatic compare_int(input logic [7:0] e);
      tally("int_oe_n", e, {7'h00, int_oe_n});
   endtask
   task automatic compare_mid(input logic [7:0] e);
      tally("midspan_mode", e, {7'h00, midspan_mode});
   endtask
   task automatic compare_block(input logic [7:0] e);
      tally("power_block", e, {4'h0, power_block});
   endtask
   task automatic compare_reset(input logic [7:0] e);
      tally("regs_reset", e, {7'h00, regs_reset});
   endtask
   task automatic compare_ack(input logic [7:0] e);
      tally("serial_data_in_line", e, {7'h00, serial_data_in_line});
   endtask
   // Oldest note is settled just after the falling edge, clear of the launching edge
   always @(negedge clock)
   begin
      #1;
      if (notes.size() > 0)
      begin
         pick = notes.pop_front();
         case (pick[11:8])
            4'h0: compare_addr(pick[7:0]);
            4'h1: compare_modes(pick[7:0]);
            4'h2: compare_switch(pick[7:0]);
            4'h3: compare_int(pick[7:0]);
            4'h4: compare_mid(pick[7:0]);
            4'h5: compare_block(pick[7:0]);
            4'h6: compare_reset(pick[7:0]);
            default: compare_ack(pick[7:0]);
         endcase
      end
   end
   // Hang guard: the pin reset alone takes about 75000 cycles
   initial
   begin
      repeat (90000) @(posedge clock);
      miscompares++;
      conclude();
   end
   initial
   begin
      seed = 8296;
      r = $random(seed);
      slave_addr_straps = r[3:0];
      idle(2);
      rst = 1'b0;
      idle(8);
      note(0, {4'h2, r[3:0]});
      note(4, 8'h01);
      note(1, 8'hff);
      slave_addr_straps = ~r[3:0];
      midspan_strap = 1'b0;
      idle(8);
      note(0, {4'h2, r[3:0]});
      note(4, 8'h01);
      mode_cmd = {1'b1, 4'h2, psc_pkg::PSC_SHUTDOWN};
      idle(1);
      mode_cmd.valid = 1'b0;
      idle(4);
      note(1, 8'hf3);
      for (int m = 0; m < 4; m++)
      begin
         mode_cmd = {1'b1, 4'h1, psc_pkg::psc_mode_t'(m[1:0])};
         idle(1);
         mode_cmd.valid = 1'b0;
         idle(4);
         note(1, {6'h3c, m[1:0]});
      end
      fault_set = r[7:4] | 4'h1;
      idle(1);
      fault_set = 4'h0;
      idle(3);
      note(3, 8'h00);
      fault_clr = 4'hf;
      idle(1);
      fault_clr = 4'h0;
      idle(3);
      note(3, 8'h01);
      port_off_n = 4'h0;
      idle(8);
      note(2, 8'h00);
      port_off_n = 4'hf;
      ac_disc_en = r[11:8] | 4'h1;
      probe_sine_lost = 1'b1;
      idle(8);
      note(5, {4'h0, ac_disc_en});
      note(2, {4'h0, 4'hd & ~ac_disc_en});
      probe_sine_lost = 1'b0;
      auto_strap = 1'b0;
      uvlo = 1'b1;
      idle(4);
      note(6, 8'h01);
      i_psc_host_model.send_addr({3'h2, ~r[3:0]});
      note(7, 8'h01);
      uvlo = 1'b0;
      idle(8);
      note(1, 8'h00);
      note(4, 8'h00);
      note(6, 8'h00);
      i_psc_host_model.send_addr({3'h2, ~r[3:0]});
      note(7, 8'h00);
      fault_set = 4'h2;
      idle(1);
      fault_set = 4'h0;
      reset_pin_n = 1'b0;
      slave_addr_straps = r[15:12];
      midspan_strap = 1'b1;
      idle(75020);
      note(6, 8'h01);
      note(3, 8'h01);
      reset_pin_n = 1'b1;
      idle(10);
      note(0, {4'h2, r[15:12]});
      note(4, 8'h01);
      idle(2);
      conclude();
   end
endmodule
bind psc_pin_ctrl psc_pin_ctrl_checker i_psc_pin_ctrl_checker (.clock, .rst, .port_off_n,
   .probe_sine_lost, .ac_disc_en, .fault_set, .fault_clr, .serial_data_out_line_oe_n,
   .int_oe_n, .slave_addr, .switch_en, .power_block, .regs_reset);
